// ==== pbl_pkg.sv ====
// Package of constants and types for the self-test and loopback block
// Functional notes
// - Receive error tally saturates at all ones
// - A write to the error count register clears the error tally
// - Continuous mode: counter at maximum pulses, restarts
// - PRBS select: back-to-back PRBS packets, checker stays on
// - Constant select: one constant packet, PRBS off
// - Size bit picks 64 or 1518 bytes
// - Generator runs only while enable is set
// - Reverse loop: forward or suppress receive data
// - MII loop: drive or suppress transmit data
// - Loop select one-hot; clear coding loop first
// - Fast Ethernet coding loop point per field value
// - Gigabit: low bit loops before signal chain
// - Lock bit shows checker synchronised
// - Lock-lost flag latched, cleared on status read
// - Busy bit shows packet generation in progress
// - Master legacy encoding status bit
// - Slave legacy encoding status bit
// - Core power status bit, one when normal
// - Reserved bits ignore writes, read zero
package pbl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam logic [4:0]  REG_RX_ERROR_COUNT    = 5'h15;
  localparam logic [4:0]  REG_SELF_TEST_CONTROL = 5'h16;
  localparam logic [4:0]  REG_TEST_POWER_STATUS = 5'h17;

  // ----------------------------------------------------------------
  // Control field positions and masks
  // ----------------------------------------------------------------
  localparam int unsigned CTL_CONT_BIT   = 15;
  localparam int unsigned CTL_PAYLD_BIT  = 14;
  localparam int unsigned CTL_SHORT_BIT  = 13;
  localparam int unsigned CTL_GEN_BIT    = 12;
  localparam int unsigned CTL_RXFWD_BIT  = 7;
  localparam int unsigned CTL_TXFWD_BIT  = 6;
  localparam int unsigned CTL_LOOP_LSB   = 2;
  localparam int unsigned CTL_CODING_LSB = 0;
  localparam logic [15:0] CTL_WRITE_MASK = 16'hf0ff;
  localparam logic [15:0] CTL_RESET      = 16'h0000;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int unsigned STS_LOCK_BIT   = 11;
  localparam int unsigned STS_LOST_BIT   = 10;
  localparam int unsigned STS_BUSY_BIT   = 9;
  localparam int unsigned STS_MLEG_BIT   = 8;
  localparam int unsigned STS_SLEG_BIT   = 7;
  localparam int unsigned STS_POWER_BIT  = 6;

  // ----------------------------------------------------------------
  // Loop selections
  // ----------------------------------------------------------------
  localparam logic [3:0] LOOP_REVERSE  = 4'h8;
  localparam logic [3:0] LOOP_EXTERNAL = 4'h4;
  localparam logic [3:0] LOOP_ANALOG   = 4'h2;
  localparam logic [3:0] LOOP_DIGITAL  = 4'h1;
  localparam logic [1:0] CODING_OFF    = 2'h0;
  localparam logic [1:0] CODING_MLT3   = 2'h3;
  localparam logic [1:0] CODING_SCR    = 2'h2;
  localparam logic [1:0] CODING_PRE    = 2'h1;

  // ----------------------------------------------------------------
  // Generator and checker constants
  // ----------------------------------------------------------------
  localparam logic [10:0] PKT_LEN_SHORT = 11'h040;
  localparam logic [10:0] PKT_LEN_LONG  = 11'h5ee;
  localparam logic [10:0] GAP_BYTES     = 11'h00c;
  localparam logic [3:0]  LOCK_MATCHES  = 4'h8;
  localparam logic [14:0] PRBS_SEED     = 15'h7fff;
  localparam logic [7:0]  CONST_BYTE    = 8'ha5;
  localparam logic [15:0] COUNT_MAX     = 16'hffff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } pbl_bus_req_t;

  typedef struct packed {
    logic gig_master_legacy;
    logic gig_slave_legacy;
    logic core_normal_power;
  } pbl_phy_status_t;

  typedef struct packed {
    logic reverse;
    logic external;
    logic analog;
    logic digital;
    logic after_mlt3;
    logic after_scrambler;
    logic before_scrambler;
    logic before_gig_chain;
    logic mac_rx_enable;
    logic mdi_tx_enable;
  } pbl_loop_t;

  typedef enum logic [1:0] {
    GEN_IDLE = 2'b00,
    GEN_SEND = 2'b01,
    GEN_GAP  = 2'b11,
    GEN_DONE = 2'b10
  } pbl_gen_state_t;

endpackage

// ==== pbl_prbs_byte.sv ====
// Byte-wide PRBS stepper used by both the generator and the checker
`timescale 1ns/1ps
module pbl_prbs_byte #(
  parameter logic [14:0] SEED = 15'h7fff
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  input  wire logic        load_i,
  input  wire logic [14:0] seed_i,
  input  wire logic        step_i,
  output logic      [7:0]  byte_o
);

  logic [14:0] state_ff;
  logic [14:0] nxt_state;

  // ----------------------------------------------------------------
  // Eight shifts of x^15 + x^14 + 1, newest bit last
  // ----------------------------------------------------------------
  always_comb begin
    logic [14:0] s;
    s = state_ff;
    for (int i = 0; i < 8; i++) begin
      s = {s[13:0], s[14] ^ s[13]};
    end
    nxt_state = s;
  end

  assign byte_o = nxt_state[7:0];

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= SEED;
    end else if (load_i) begin
      state_ff <= seed_i;
    end else if (step_i) begin
      state_ff <= nxt_state;
    end
  end

endmodule

// ==== pbl_self_test.sv ====
// Self-test, loopback control and receive error tally
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module pbl_self_test #(
  parameter logic [7:0] CONST_DATA = pbl_pkg::CONST_BYTE
) (
  input  wire logic                     mclk_i,
  input  wire logic                     reset_n_i,
  input  wire pbl_pkg::pbl_bus_req_t    bus_req_i,
  output logic      [15:0]              rd_data_o,
  input  wire logic                     rx_error_i,
  input  wire logic                     rx_valid_i,
  input  wire logic [7:0]               rx_byte_i,
  input  wire logic                     speed_100_i,
  input  wire logic                     speed_1000_i,
  input  wire pbl_pkg::pbl_phy_status_t phy_status_i,
  output logic                          tx_valid_o,
  output logic      [7:0]               tx_byte_o,
  output logic                          tx_last_o,
  output logic                          counter_wrap_o,
  output logic      [15:0]              packet_count_o,
  output logic      [15:0]              prbs_error_count_o,
  output pbl_pkg::pbl_loop_t            loop_o
);
  import pbl_pkg::*;

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  wire logic wr_rxerr = bus_req_i.wr && (bus_req_i.addr == REG_RX_ERROR_COUNT);
  wire logic wr_ctrl  = bus_req_i.wr &&
                        (bus_req_i.addr == REG_SELF_TEST_CONTROL);
  wire logic rd_stat  = bus_req_i.rd &&
                        (bus_req_i.addr == REG_TEST_POWER_STATUS);

  logic [15:0]    rx_error_tally_ff;
  logic [15:0]    ctrl_ff;
  logic [15:0]    rd_data_ff;
  logic           checker_locked_ff;
  logic           checker_lock_dropped_ff;
  logic [3:0]     match_cnt_ff;
  logic [7:0]     prev_byte_ff;
  pbl_gen_state_t state_ff;
  logic [10:0]    byte_cnt_ff;
  logic           tx_valid_ff;
  logic [7:0]     tx_byte_ff;
  logic           tx_last_ff;
  logic [15:0]    pkt_cnt_ff;
  logic [15:0]    err_cnt_ff;
  logic           wrap_ff;
  pbl_loop_t      loop_ff;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  wire logic       prbs_continuous_enable = ctrl_ff[CTL_CONT_BIT];
  wire logic       prbs_payload_select    = ctrl_ff[CTL_PAYLD_BIT];
  wire logic       short_packet_select    = ctrl_ff[CTL_SHORT_BIT];
  wire logic       generator_enable       = ctrl_ff[CTL_GEN_BIT];
  wire logic       reverse_loop_rx_forward = ctrl_ff[CTL_RXFWD_BIT];
  wire logic       mii_loop_tx_forward    = ctrl_ff[CTL_TXFWD_BIT];
  wire logic [3:0] loop_select = ctrl_ff[CTL_LOOP_LSB +: 4];
  wire logic [1:0] coding_layer_loop_select = ctrl_ff[CTL_CODING_LSB +: 2];

  // Loop select may only move while the coding loop is off
  wire logic [15:0] wr_val  = bus_req_i.wdata & CTL_WRITE_MASK;
  wire logic [3:0]  new_loop = (coding_layer_loop_select == CODING_OFF) ?
                               wr_val[CTL_LOOP_LSB +: 4] : loop_select;
  wire logic new_rxfwd = wr_val[CTL_RXFWD_BIT] &&
                         (new_loop == LOOP_REVERSE);
  wire logic new_txfwd = wr_val[CTL_TXFWD_BIT] &&
                         (new_loop == LOOP_DIGITAL);
  wire logic [15:0] nxt_ctrl = {wr_val[15:8], new_rxfwd, new_txfwd,
                                new_loop, wr_val[1:0]};

  // ----------------------------------------------------------------
  // Receive error tally
  // ----------------------------------------------------------------
  wire logic [15:0] tally_base = wr_rxerr ? 16'h0000 : rx_error_tally_ff;
  wire logic [15:0] nxt_tally  = (rx_error_i && (tally_base != COUNT_MAX)) ?
                                 tally_base + 16'h0001 : tally_base;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_error_tally_ff <= 16'h0000;
      ctrl_ff           <= CTL_RESET;
    end else begin
      rx_error_tally_ff <= nxt_tally;
      if (wr_ctrl) begin
        ctrl_ff <= nxt_ctrl;
      end
    end
  end

  // ----------------------------------------------------------------
  // Generator state machine
  // ----------------------------------------------------------------
  wire logic [10:0] pkt_last = short_packet_select ? PKT_LEN_SHORT - 11'h001 :
                               PKT_LEN_LONG - 11'h001;
  wire logic        at_last  = (byte_cnt_ff == pkt_last);
  wire logic        gap_end  = (byte_cnt_ff == GAP_BYTES - 11'h001);
  wire logic        sending  = (state_ff == GEN_SEND);
  wire logic        pkt_end  = sending && at_last;
  wire logic        generator_active = sending || (state_ff == GEN_GAP);

  logic           nxt_state_gen;
  pbl_gen_state_t nxt_state;
  logic [10:0]    nxt_byte_cnt;

  always_comb begin
    nxt_state     = state_ff;
    nxt_byte_cnt  = byte_cnt_ff;
    nxt_state_gen = 1'b0;
    case (state_ff)
      GEN_IDLE: begin
        nxt_byte_cnt = 11'h000;
        if (generator_enable) begin
          nxt_state = GEN_SEND;
        end
      end
      GEN_SEND: begin
        nxt_byte_cnt = byte_cnt_ff + 11'h001;
        if (at_last) begin
          nxt_byte_cnt = 11'h000;
          nxt_state    = prbs_payload_select ? GEN_GAP : GEN_DONE;
        end
      end
      GEN_GAP: begin
        nxt_byte_cnt = byte_cnt_ff + 11'h001;
        if (gap_end) begin
          nxt_byte_cnt = 11'h000;
          nxt_state    = GEN_SEND;
        end
      end
      default: begin
        nxt_byte_cnt = 11'h000;
      end
    endcase
    if (!generator_enable) begin
      nxt_state    = GEN_IDLE;
      nxt_byte_cnt = 11'h000;
    end
    nxt_state_gen = sending && prbs_payload_select;
  end

  // ----------------------------------------------------------------
  // PRBS generator and checker engines
  // ----------------------------------------------------------------
  logic [7:0] gen_byte;
  logic [7:0] chk_byte;

  pbl_prbs_byte #(
    .SEED (PRBS_SEED)
  ) u_gen (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .load_i    (1'b0),
    .seed_i    (PRBS_SEED),
    .step_i    (nxt_state_gen),
    .byte_o    (gen_byte)
  );

  // Checker runs whenever PRBS payload is selected, generator or not
  wire logic chk_active = prbs_payload_select && rx_valid_i;
  wire logic chk_match  = (rx_byte_i == chk_byte);
  wire logic chk_load   = chk_active && !chk_match;
  wire logic lock_lost  = chk_load && checker_locked_ff;

  pbl_prbs_byte #(
    .SEED (PRBS_SEED)
  ) u_chk (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .load_i    (chk_load),
    .seed_i    ({prev_byte_ff[6:0], rx_byte_i}),
    .step_i    (chk_active && chk_match),
    .byte_o    (chk_byte)
  );

  // ----------------------------------------------------------------
  // Counters with continuous wrap or saturation
  // ----------------------------------------------------------------
  function automatic logic [16:0] count_step(input logic [15:0] cnt,
                                             input logic        inc,
                                             input logic        cont);
    logic [16:0] res;
    res = {1'b0, cnt};
    if (inc) begin
      if (cnt != COUNT_MAX) begin
        res = {1'b0, cnt + 16'h0001};
      end else if (cont) begin
        res = {1'b1, 16'h0000};
      end
    end
    return res;
  endfunction

  wire logic [16:0] pkt_step = count_step(pkt_cnt_ff,
                                          pkt_end && prbs_payload_select,
                                          prbs_continuous_enable);
  wire logic [16:0] err_step = count_step(err_cnt_ff, chk_load,
                                          prbs_continuous_enable);

  // ----------------------------------------------------------------
  // Generator, checker and counter registers
  // ----------------------------------------------------------------
  wire logic [3:0] nxt_match = (match_cnt_ff == LOCK_MATCHES) ?
                               match_cnt_ff : match_cnt_ff + 4'h1;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff    <= GEN_IDLE;
      byte_cnt_ff <= 11'h000;
    end else begin
      state_ff    <= nxt_state;
      byte_cnt_ff <= nxt_byte_cnt;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_valid_ff <= 1'b0;
      tx_byte_ff  <= 8'h00;
      tx_last_ff  <= 1'b0;
    end else begin
      tx_valid_ff <= sending;
      tx_byte_ff  <= prbs_payload_select ? gen_byte : CONST_DATA;
      tx_last_ff  <= pkt_end;
    end
  end

  // ----------------------------------------------------------------
  // Packet and checker error counters
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pkt_cnt_ff <= 16'h0000;
      err_cnt_ff <= 16'h0000;
      wrap_ff    <= 1'b0;
    end else begin
      pkt_cnt_ff <= pkt_step[15:0];
      err_cnt_ff <= err_step[15:0];
      wrap_ff    <= pkt_step[16] || err_step[16];
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      checker_locked_ff <= 1'b0;
      match_cnt_ff      <= 4'h0;
      prev_byte_ff      <= 8'h00;
    end else if (!prbs_payload_select) begin
      checker_locked_ff <= 1'b0;
      match_cnt_ff      <= 4'h0;
    end else if (rx_valid_i) begin
      prev_byte_ff <= rx_byte_i;
      if (chk_match) begin
        match_cnt_ff      <= nxt_match;
        checker_locked_ff <= (nxt_match == LOCK_MATCHES);
      end else begin
        match_cnt_ff      <= 4'h0;
        checker_locked_ff <= 1'b0;
      end
    end
  end

  // New loss in the clearing read cycle stays latched
  wire logic nxt_dropped = lock_lost ||
                           (checker_lock_dropped_ff && !rd_stat);

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      checker_lock_dropped_ff <= 1'b0;
    end else begin
      checker_lock_dropped_ff <= nxt_dropped;
    end
  end

  // ----------------------------------------------------------------
  // Loop point decode
  // ----------------------------------------------------------------
  pbl_loop_t nxt_loop;
  wire logic coding_fast = speed_100_i && !speed_1000_i;

  assign nxt_loop.reverse  = (loop_select == LOOP_REVERSE);
  assign nxt_loop.external = (loop_select == LOOP_EXTERNAL);
  assign nxt_loop.analog   = (loop_select == LOOP_ANALOG);
  assign nxt_loop.digital  = (loop_select == LOOP_DIGITAL);
  assign nxt_loop.after_mlt3 = coding_fast &&
         (coding_layer_loop_select == CODING_MLT3);
  assign nxt_loop.after_scrambler = coding_fast &&
         (coding_layer_loop_select == CODING_SCR);
  assign nxt_loop.before_scrambler = coding_fast &&
         (coding_layer_loop_select == CODING_PRE);
  assign nxt_loop.before_gig_chain = speed_1000_i &&
         coding_layer_loop_select[0];
  assign nxt_loop.mac_rx_enable = !nxt_loop.reverse ||
         reverse_loop_rx_forward;
  assign nxt_loop.mdi_tx_enable = !nxt_loop.digital ||
         mii_loop_tx_forward;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      loop_ff <= '0;
    end else begin
      loop_ff <= nxt_loop;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire logic [15:0] status_word = {4'h0,
                                   checker_locked_ff,
                                   checker_lock_dropped_ff,
                                   generator_active,
                                   phy_status_i.gig_master_legacy,
                                   phy_status_i.gig_slave_legacy,
                                   phy_status_i.core_normal_power,
                                   6'h00};

  wire logic [15:0] rd_value =
    (bus_req_i.addr == REG_RX_ERROR_COUNT)    ? rx_error_tally_ff :
    (bus_req_i.addr == REG_SELF_TEST_CONTROL) ? ctrl_ff :
    (bus_req_i.addr == REG_TEST_POWER_STATUS) ? status_word : 16'h0000;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_ff <= 16'h0000;
    end else begin
      rd_data_ff <= bus_req_i.rd ? rd_value : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data_o          = rd_data_ff;
  assign tx_valid_o         = tx_valid_ff;
  assign tx_byte_o          = tx_byte_ff;
  assign tx_last_o          = tx_last_ff;
  assign counter_wrap_o     = wrap_ff;
  assign packet_count_o     = pkt_cnt_ff;
  assign prbs_error_count_o = err_cnt_ff;
  assign loop_o             = loop_ff;

endmodule

// ==== pbl_self_test_assertions.sv ====
// Port-level assertions for the self-test and loopback block
`timescale 1ns/1ps
module pbl_self_test_assertions (
  input wire logic                     mclk_i,
  input wire logic                     reset_n_i,
  input wire pbl_pkg::pbl_bus_req_t    bus_req_i,
  input wire logic [15:0]              rd_data_o,
  input wire logic                     rx_error_i,
  input wire pbl_pkg::pbl_phy_status_t phy_status_i,
  input wire logic                     tx_valid_o,
  input wire logic                     tx_last_o,
  input wire pbl_pkg::pbl_loop_t       loop_o
);
  import pbl_pkg::*;
  logic [15:0] tally_ff;
  logic [15:0] nxt_tally;
  logic [10:0] run_ff;
  logic [10:0] nxt_run;
  wire rd_cnt = bus_req_i.rd && bus_req_i.addr == REG_RX_ERROR_COUNT;
  wire wr_cnt = bus_req_i.wr && bus_req_i.addr == REG_RX_ERROR_COUNT;
  wire rd_ctl = bus_req_i.rd && bus_req_i.addr == REG_SELF_TEST_CONTROL;
  wire rd_sts = bus_req_i.rd && bus_req_i.addr == REG_TEST_POWER_STATUS;
  wire [3:0] sel = {loop_o.reverse, loop_o.external, loop_o.analog,
                    loop_o.digital};
  wire [3:0] pnt = {loop_o.after_mlt3, loop_o.after_scrambler,
                    loop_o.before_scrambler, loop_o.before_gig_chain};
  // Shadow of the error tally and of the running packet length
  assign nxt_tally = wr_cnt ? {15'h0000, rx_error_i} :
                     (rx_error_i && tally_ff != COUNT_MAX) ?
                     tally_ff + 16'h0001 : tally_ff;
  assign nxt_run = (tx_valid_o && !tx_last_o) ? run_ff + 11'h001 : 11'h000;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tally_ff <= 16'h0000;
      run_ff   <= 11'h000;
    end else begin
      tally_ff <= nxt_tally;
      run_ff   <= nxt_run;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  AST_TALLY_VALUE:
    assert property (rd_cnt |=> rd_data_o == $past(tally_ff))
    else $error("error tally read mismatch");
  AST_CTL_RESERVED:
    assert property (rd_ctl |=> rd_data_o[11:8] == 4'h0)
    else $error("control reserved bits not zero");
  AST_STS_RESERVED:
    assert property (rd_sts |=> rd_data_o[15:12] == 4'h0
                     && rd_data_o[5:0] == 6'h00)
    else $error("status reserved bits not zero");
  AST_STS_PHY:
    assert property (rd_sts |=> rd_data_o[8:6] == $past(phy_status_i))
    else $error("status phy bits mismatch");
  AST_PKT_LEN:
    assert property (tx_last_o |-> tx_valid_o
                     && (run_ff == 11'h03f || run_ff == 11'h5ed))
    else $error("packet length wrong");
  AST_PKT_GAP:
    assert property (tx_last_o |=> !tx_valid_o [*8])
    else $error("byte sent right after packet end");
  AST_LOOP_ONEHOT:
    assert property ($onehot0(sel))
    else $error("more than one loop selected");
  AST_POINT_ONEHOT:
    assert property ($onehot0(pnt))
    else $error("more than one coding loop point");
endmodule
bind pbl_self_test pbl_self_test_assertions u_assert (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus_req_i(bus_req_i),
  .rd_data_o(rd_data_o), .rx_error_i(rx_error_i),
  .phy_status_i(phy_status_i), .tx_valid_o(tx_valid_o),
  .tx_last_o(tx_last_o), .loop_o(loop_o));

// ==== pbl_self_test_test.sv ====
// Self-checking testbench for the self-test and loopback block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  failures++; $display("unexpected %s expected %h seen %h", nm, e, g); \
  end end
module pbl_self_test_test;
  import pbl_pkg::*;
  typedef struct packed {
    logic [15:0] val;
    logic [15:0] msk;
  } pbl_exp_t;
  logic            mclk_i = 1'b0;
  logic            reset_n_i = 1'b0;
  pbl_bus_req_t    bus_req_i = '0;
  logic [15:0]     rd_data_o;
  logic            rx_error_i = 1'b0;
  logic            rx_valid_i = 1'b0;
  logic [7:0]      rx_byte_i = 8'h00;
  logic            speed_1000_i = 1'b0;
  pbl_phy_status_t phy_status_i = '0;
  logic            tx_valid_o;
  logic [7:0]      tx_byte_o;
  logic            tx_last_o;
  pbl_loop_t       loop_o;
  logic            speed_100_i = 1'b1;
  logic            counter_wrap_o;
  logic [15:0]     packet_count_o;
  logic [15:0]     prbs_error_count_o;
  pbl_exp_t        exp_q[$];
  pbl_exp_t        got_e;
  logic            rd_dly = 1'b0;
  logic            loop_on = 1'b0;
  logic            corrupt = 1'b0;
  logic [3:0]      sel [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
  logic [7:0]      cg [6] = '{8'hb8, 8'ha4, 8'h92, 8'hd1, 8'hf1, 8'h30};
  int              failures = 0;
  int              num_checks = 0;
  int              n;
  integer          seed = 32'h1ab5;
  wire [3:0] lsel = {loop_o.reverse, loop_o.external, loop_o.analog,
                     loop_o.digital};
  wire [3:0] lpnt = {loop_o.after_mlt3, loop_o.after_scrambler,
                     loop_o.before_scrambler, loop_o.before_gig_chain};
  pbl_self_test dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus_req_i(bus_req_i),
    .rd_data_o(rd_data_o), .rx_error_i(rx_error_i),
    .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i),
    .speed_100_i(speed_100_i), .speed_1000_i(speed_1000_i),
    .phy_status_i(phy_status_i),
    .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o), .tx_last_o(tx_last_o),
    .counter_wrap_o(counter_wrap_o), .packet_count_o(packet_count_o),
    .prbs_error_count_o(prbs_error_count_o), .loop_o(loop_o));
  task automatic print_verdict();
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_i);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    bus_req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    cyc(1);
    bus_req_i <= '0;
    cyc(1);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] v, m);
    exp_q.push_back('{val: v, msk: m});
    bus_req_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    cyc(1);
    bus_req_i <= '0;
    cyc(1);
  endtask
  task automatic pkt(input int len, input logic cst);
    int cnt;
    cnt = 0;
    for (int i = 0; i < 4000; i++) begin
      @(negedge mclk_i);
      if (tx_valid_o === 1'b1) begin
        cnt++;
        if (cst) `CHK("const byte", CONST_BYTE, tx_byte_o)
        if (tx_last_o === 1'b1) break;
      end
    end
    `CHK("packet length", len, cnt)
    cyc(1);
  endtask
  task automatic idle();
    int cnt;
    cnt = 0;
    repeat (100) begin
      @(negedge mclk_i);
      if (tx_valid_o !== 1'b0) cnt++;
    end
    `CHK("idle bytes", 0, cnt)
  endtask
  initial forever #20 mclk_i = ~mclk_i;
  // Loopback of generated bytes into the checker, noise otherwise
  always @(posedge mclk_i) begin
    rx_valid_i <= loop_on & tx_valid_o;
    rx_byte_i  <= loop_on ? tx_byte_o ^ {8{corrupt}} : 8'($random(seed));
  end
  always @(posedge mclk_i) rd_dly <= bus_req_i.rd;
  always @(negedge mclk_i)
    if (counter_wrap_o !== 1'b0) `CHK("wrap", 1'b0, counter_wrap_o)
  always @(negedge mclk_i) begin
    if (rd_dly && exp_q.size() > 0) begin
      got_e = exp_q.pop_front();
      `CHK("read data", got_e.val, rd_data_o & got_e.msk)
    end
  end
  initial begin
    #(40 * 80000);
    failures++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    cyc(1);
    rd(REG_RX_ERROR_COUNT, 16'h0000, 16'hffff);
    rd(REG_SELF_TEST_CONTROL, 16'h0000, 16'hffff);
    wr(5'h05, 16'($random(seed)));
    rd(5'h05, 16'h0000, 16'hffff);
    for (int i = 0; i < 8; i++) begin
      phy_status_i <= 3'(i);
      cyc(1);
      rd(REG_TEST_POWER_STATUS, {7'h00, 3'(i), 6'h00}, 16'hffff);
    end
    foreach (sel[i]) begin
      wr(REG_SELF_TEST_CONTROL, {8'h0f, 2'b00, sel[i], 2'b00});
      rd(REG_SELF_TEST_CONTROL, {10'h000, sel[i], 2'b00}, 16'hffff);
      `CHK("loop select", sel[i], lsel)
    end
    wr(REG_SELF_TEST_CONTROL, 16'h00e0);
    rd(REG_SELF_TEST_CONTROL, 16'h00a0, 16'hffff);
    `CHK("rx forward", 1'b1, loop_o.mac_rx_enable)
    wr(REG_SELF_TEST_CONTROL, 16'h0020);
    cyc(1);
    `CHK("rx forward", 1'b0, loop_o.mac_rx_enable)
    wr(REG_SELF_TEST_CONTROL, 16'h00c4);
    rd(REG_SELF_TEST_CONTROL, 16'h0044, 16'hffff);
    `CHK("tx forward", 1'b1, loop_o.mdi_tx_enable)
    wr(REG_SELF_TEST_CONTROL, 16'h0004);
    cyc(1);
    `CHK("tx forward", 1'b0, loop_o.mdi_tx_enable)
    for (int i = 0; i < 6; i++) begin
      speed_100_i  <= cg[i][7];
      speed_1000_i <= cg[i][6];
      wr(REG_SELF_TEST_CONTROL, {10'h000, LOOP_DIGITAL, cg[i][5:4]});
      cyc(1);
      `CHK("loop point", cg[i][3:0], lpnt)
    end
    wr(REG_SELF_TEST_CONTROL, 16'h0023);
    rd(REG_SELF_TEST_CONTROL, 16'h0007, 16'hffff);
    speed_1000_i <= 1'b0;
    speed_100_i  <= 1'b1;
    wr(REG_SELF_TEST_CONTROL, 16'h0004);
    wr(REG_SELF_TEST_CONTROL, 16'h0000);
    n = 5 + ($random(seed) & 15);
    repeat (n) begin
      rx_error_i <= 1'b1;
      cyc(1);
      rx_error_i <= 1'b0;
      cyc(1 + ($random(seed) & 3));
    end
    rd(REG_RX_ERROR_COUNT, 16'(n), 16'hffff);
    rx_error_i <= 1'b1;
    cyc(65540);
    rx_error_i <= 1'b0;
    rd(REG_RX_ERROR_COUNT, 16'hffff, 16'hffff);
    wr(REG_RX_ERROR_COUNT, 16'($random(seed)));
    rd(REG_RX_ERROR_COUNT, 16'h0000, 16'hffff);
    wr(REG_SELF_TEST_CONTROL, 16'hb000);
    pkt(64, 1'b1);
    rd(REG_TEST_POWER_STATUS, 16'h0000, 16'h0200);
    idle();
    wr(REG_SELF_TEST_CONTROL, 16'h8000);
    loop_on <= 1'b1;
    wr(REG_SELF_TEST_CONTROL, 16'hd000);
    pkt(1518, 1'b0);
    rd(REG_TEST_POWER_STATUS, 16'h0a00, 16'h0e00);
    `CHK("packet count", 16'h0001, packet_count_o)
    `CHK("checker errors", 16'h0000, prbs_error_count_o)
    corrupt <= 1'b1;
    cyc(20);
    corrupt <= 1'b0;
    cyc(40);
    `CHK("errors seen", 1'b1, prbs_error_count_o != 16'h0000)
    rd(REG_TEST_POWER_STATUS, 16'h0400, 16'h0400);
    rd(REG_TEST_POWER_STATUS, 16'h0000, 16'h0400);
    wr(REG_SELF_TEST_CONTROL, 16'h8000);
    cyc(2);
    idle();
    wr(REG_SELF_TEST_CONTROL, 16'hf000);
    pkt(64, 1'b0);
    pkt(64, 1'b0);
    wr(REG_SELF_TEST_CONTROL, 16'h8000);
    cyc(4);
    print_verdict();
  end
endmodule
